/* inc/pf_port_cfg.svh */
// constants of the group-zero port controller: offsets, fields, resets
// assumes 16-bit registers on a byte-addressed plain register port
`ifndef PF_PORT_CFG_SVH
`define PF_PORT_CFG_SVH

`define PF_ADDR_W          5
`define PF_DATA_W          16
`define PF_OFS_CLK_CTRL    5'h00
`define PF_OFS_GRP_SUM     5'h02
`define PF_OFS_DATA        5'h04
`define PF_OFS_IO_EN       5'h06
`define PF_OFS_PULL        5'h08
`define PF_OFS_IRQ_FLAGS   5'h0a
`define PF_OFS_IRQ_CTRL    5'h0c
`define PF_OFS_FILT_EN     5'h0e
`define PF_OFS_MODE_SEL    5'h10
`define PF_OFS_FUNC_SEL    5'h12

`define PF_CLK_SRC_LSB     0
`define PF_CLK_KRST_LSB    2
`define PF_CLK_DIV_LSB     4
`define PF_CLK_DEBUG_RUN_BIT   8
`define PF_HI_LSB          8
`define PF_RESET_VAL       16'h0000
`define PF_SRC_PRESENT     4'h7
`define PF_GRP_IRQ_MASK    13'h0007
`define PF_FILT_DEPTH      3

`endif

/* inc/pf_port_pkg.sv */
// types of the group-zero port controller
// assumes pf_port_cfg.svh holds all numeric constants
package pf_port_pkg;

    // clock source codes of the port operating clock
    typedef enum logic [1:0] {
        PF_SRC_INTERNAL,
        PF_SRC_LOW_SPEED,
        PF_SRC_HIGH_SPEED,
        PF_SRC_EXTERNAL
    } pf_src_t;

    // pin function codes used while the peripheral mode bit is set
    typedef enum logic [1:0] {
        PF_FN_DEDICATED,
        PF_FN_UNIVERSAL_PORT_MULTIPLEXER,
        PF_FN_SPARE2,
        PF_FN_SPARE3
    } pf_func_t;

endpackage : pf_port_pkg

/* rtl/pf_chat_filter.sv */
// chattering filter for a group of port inputs
// assumes sample_i is a one-cycle enable from the port clock divider
`timescale 1ns/1ps
`default_nettype none

module pf_chat_filter
    import pf_port_pkg::*;
#(
    parameter int WIDTH = 7,
    parameter int DEPTH = 3
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // control
    input  wire logic             sample_i,
    input  wire logic [WIDTH-1:0] enable_i,
    // data
    input  wire logic [WIDTH-1:0] raw_i,
    output logic      [WIDTH-1:0] filt_o
);

    logic [WIDTH-1:0] hist_r   [DEPTH];
    logic [WIDTH-1:0] hist_nxt [DEPTH];
    logic [WIDTH-1:0] stable_r;
    logic [WIDTH-1:0] stable_nxt;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] out_nxt;

    // a level only counts once DEPTH samples in a row agree
    always_comb begin
        logic [WIDTH-1:0] all_hi;
        logic [WIDTH-1:0] all_lo;
        all_hi = '1;
        all_lo = '1;
        for (int i = 0; i < DEPTH; i++) begin
            all_hi = all_hi & hist_r[i];
            all_lo = all_lo & ~hist_r[i];
        end
        for (int i = 0; i < DEPTH; i++) begin
            hist_nxt[i] = hist_r[i];
        end
        if (sample_i) begin
            hist_nxt[0] = raw_i;
            for (int i = 1; i < DEPTH; i++) begin
                hist_nxt[i] = hist_r[i-1];
            end
        end
        stable_nxt = (stable_r | all_hi) & ~all_lo;
        // bypass takes the pin directly, without the sampling delay
        out_nxt    = (enable_i & stable_r) | (~enable_i & raw_i);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                hist_r[i] <= '0;
            end
            stable_r <= '0;
            out_r    <= '0;
        end else begin
            hist_r   <= hist_nxt;
            stable_r <= stable_nxt;
            out_r    <= out_nxt;
        end
    end

    assign filt_o = out_r;

endmodule : pf_chat_filter

`default_nettype wire

/* rtl/pf_port_ctrl.sv */
// group-zero port controller: clock setup, key reset, pins, registers
// assumes source clock ticks are one-cycle enables on clock_i
//
// Operation
// - key reset when lowest two, three or four inputs low, codes 1-3.
// - four-bit divider sets port clock ratio, also the filter clock.
// - two-bit source field picks internal, low, high or external.
// - divider code n divides by two to the power n.
// - filter samples at the divided source rate.
// - source codes of absent sources are not accepted.
// - port clock stops in debug mode unless debug run is set.
// - summary bit reads one while its group has a pending flag.
// - summary bit clears once the causing flag is cleared.
// - summary bits only for interrupt groups; bits 15-13 read zero.
// - seven pins, bits 6-0; bits 7 and 15 read zero.
// - data register: outputs 14-8 writable, inputs 6-0 read-only.
// - writing one clears an interrupt flag; zero leaves it.
// - two-bit function field per pin in 13-0; 15-14 read zero.
// - function 0 routes dedicated peripheral, 1 the port multiplexer.
// - mode bit 0 selects general I/O, 1 the peripheral function.
// - edge bit 1 flags falling edges, 0 rising edges.
// - filter enable 0 bypasses the filter, 1 uses it.
// - output enable 0 floats the pin, 1 drives the data bit.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pf_port_cfg.svh"

module pf_port_ctrl
    import pf_port_pkg::*;
#(
    parameter int          PINS          = 7,
    parameter logic [3:0]  SRC_PRESENT   = `PF_SRC_PRESENT,
    parameter logic [12:0] GRP_IRQ_MASK  = `PF_GRP_IRQ_MASK
) (
    // clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    // register port
    input  wire logic [`PF_ADDR_W-1:0] reg_addr_i,
    input  wire logic [`PF_DATA_W-1:0] reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [`PF_DATA_W-1:0] reg_rdata_o,
    // clock sources and debug state
    input  wire logic [3:0]            src_tick_i,
    input  wire logic                  debug_mode_i,
    // pins
    input  wire logic [PINS-1:0]       pin_in_i,
    output logic      [PINS-1:0]       pin_out_o,
    output logic      [PINS-1:0]       pin_oe_n_o,
    output logic      [PINS-1:0]       pull_enable_o,
    output logic      [PINS-1:0]       pull_direction_o,
    // peripheral side
    input  wire logic [PINS-1:0]       periph_out_i,
    input  wire logic [PINS-1:0]       periph_oe_i,
    output logic      [PINS-1:0]       periph_in_o,
    input  wire logic [PINS-1:0]       universal_port_multiplexer_out_i,
    input  wire logic [PINS-1:0]       universal_port_multiplexer_oe_i,
    output logic      [PINS-1:0]       universal_port_multiplexer_in_o,
    // other groups and system
    input  wire logic [12:1]           group_pending_i,
    output logic                       group0_pending_o,
    output logic                       key_reset_o
);

    ////////////////////////////////////////////////////////////////////
    // register state

    logic            debug_run_r,  debug_run_nxt;
    logic [3:0]      clk_div_r,    clk_div_nxt;
    logic [1:0]      key_cfg_r,    key_cfg_nxt;
    pf_src_t         clk_src_r,    clk_src_nxt;
    logic [PINS-1:0] out_val_r,    out_val_nxt;
    logic [PINS-1:0] in_en_r,      in_en_nxt;
    logic [PINS-1:0] out_en_r,     out_en_nxt;
    logic [PINS-1:0] pull_dir_r,   pull_dir_nxt;
    logic [PINS-1:0] pull_en_r,    pull_en_nxt;
    logic [PINS-1:0] flags_r,      flags_nxt;
    logic [PINS-1:0] edge_sel_r,   edge_sel_nxt;
    logic [PINS-1:0] irq_en_r,     irq_en_nxt;
    logic [PINS-1:0] filt_en_r,    filt_en_nxt;
    logic [PINS-1:0] mode_r,       mode_nxt;
    logic [2*PINS-1:0] func_r,     func_nxt;
    logic [15:0]     rdata_r,      rdata_nxt;

    logic [PINS-1:0] filt_in;
    logic [PINS-1:0] in_val;
    logic [PINS-1:0] prev_in_r,    prev_in_nxt;
    logic [PINS-1:0] pin_event;
    logic [12:0]     grp_sum;
    logic [15:0]     rd_mux;
    logic [14:0]     div_cnt_r,    div_cnt_nxt;
    logic            port_tick;
    logic            src_tick_sel;
    logic            clk_run;
    logic            key_hit;
    logic            key_rst_r,    key_rst_nxt;
    pf_src_t         src_wr;

    function automatic logic [14:0] div_mask(input logic [3:0] code);
        div_mask = 15'((32'h1 << code) - 32'h1);
    endfunction : div_mask

    function automatic logic [15:0] pack_hi_lo(input logic [PINS-1:0] hi,
                                               input logic [PINS-1:0] lo);
        pack_hi_lo = '0;
        pack_hi_lo[`PF_HI_LSB +: PINS] = hi;
        pack_hi_lo[PINS-1:0]           = lo;
    endfunction : pack_hi_lo

    function automatic logic wr_at(input logic [`PF_ADDR_W-1:0] ofs);
        wr_at = reg_wr_i && (reg_addr_i == ofs);
    endfunction : wr_at

    ////////////////////////////////////////////////////////////////////
    // port operating clock: source select and power-of-two divider

    assign src_wr  = pf_src_t'(reg_wdata_i[`PF_CLK_SRC_LSB +: 2]);
    assign clk_run = debug_run_r || !debug_mode_i;
    assign src_tick_sel = src_tick_i[clk_src_r];

    always_comb begin
        port_tick   = 1'b0;
        div_cnt_nxt = div_cnt_r;
        if (clk_run && src_tick_sel) begin
            // tick when the low n bits have all counted up
            if ((div_cnt_r & div_mask(clk_div_r)) == div_mask(clk_div_r))
            begin
                port_tick   = 1'b1;
                div_cnt_nxt = '0;
            end else begin
                div_cnt_nxt = div_cnt_r + 15'h0001;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // input path, filter and pin events

    pf_chat_filter #(
        .WIDTH    (PINS),
        .DEPTH    (`PF_FILT_DEPTH)
    ) u_filter (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .sample_i (port_tick),
        .enable_i (filt_en_r),
        .raw_i    (pin_in_i),
        .filt_o   (filt_in)
    );

    // peripheral pins and disabled inputs read as zero
    assign in_val      = filt_in & in_en_r & ~mode_r;
    assign prev_in_nxt = in_val;
    assign pin_event   = irq_en_r & ((edge_sel_r & prev_in_r & ~in_val) |
                                     (~edge_sel_r & ~prev_in_r & in_val));

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_in_r <= '0;
        end else begin
            prev_in_r <= prev_in_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // key-entry reset, held while the selected inputs stay low

    always_comb begin
        unique case (key_cfg_r)
            2'h0: key_hit = 1'b0;
            2'h1: key_hit = ~|filt_in[1:0];
            2'h2: key_hit = ~|filt_in[2:0];
            2'h3: key_hit = ~|filt_in[3:0];
        endcase
        key_rst_nxt = key_hit;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_rst_r <= 1'b0;
        end else begin
            key_rst_r <= key_rst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin output and peripheral routing

    always_comb begin
        pin_out_o        = '0;
        pin_oe_n_o       = '1;
        pull_enable_o    = '0;
        pull_direction_o = pull_dir_r;
        periph_in_o      = '0;
        universal_port_multiplexer_in_o       = '0;
        for (int i = 0; i < PINS; i++) begin
            if (!mode_r[i]) begin
                pin_out_o[i]     = out_val_r[i];
                pin_oe_n_o[i]    = ~out_en_r[i];
                // pulls only act on an undriven general-purpose pin
                pull_enable_o[i] = pull_en_r[i] & ~out_en_r[i];
            end else begin
                unique case (pf_func_t'(func_r[2*i +: 2]))
                    PF_FN_DEDICATED: begin
                        pin_out_o[i]   = periph_out_i[i];
                        pin_oe_n_o[i]  = ~periph_oe_i[i];
                        periph_in_o[i] = pin_in_i[i];
                    end
                    PF_FN_UNIVERSAL_PORT_MULTIPLEXER: begin
                        pin_out_o[i]   = universal_port_multiplexer_out_i[i];
                        pin_oe_n_o[i]  = ~universal_port_multiplexer_oe_i[i];
                        universal_port_multiplexer_in_o[i]  = pin_in_i[i];
                    end
                    PF_FN_SPARE2, PF_FN_SPARE3: begin
                        pin_oe_n_o[i]  = 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers: write decode and read mux

    assign grp_sum = GRP_IRQ_MASK & {group_pending_i, |flags_r};

    always_comb begin
        debug_run_nxt = debug_run_r;
        clk_div_nxt   = clk_div_r;
        key_cfg_nxt   = key_cfg_r;
        clk_src_nxt   = clk_src_r;
        out_val_nxt   = out_val_r;
        in_en_nxt     = in_en_r;
        out_en_nxt    = out_en_r;
        pull_dir_nxt  = pull_dir_r;
        pull_en_nxt   = pull_en_r;
        edge_sel_nxt  = edge_sel_r;
        irq_en_nxt    = irq_en_r;
        filt_en_nxt   = filt_en_r;
        mode_nxt      = mode_r;
        func_nxt      = func_r;
        if (wr_at(`PF_OFS_CLK_CTRL)) begin
            debug_run_nxt = reg_wdata_i[`PF_CLK_DEBUG_RUN_BIT];
            clk_div_nxt   = reg_wdata_i[`PF_CLK_DIV_LSB +: 4];
            key_cfg_nxt   = reg_wdata_i[`PF_CLK_KRST_LSB +: 2];
            // an absent source keeps the previous selection
            if (SRC_PRESENT[src_wr]) begin
                clk_src_nxt = src_wr;
            end
        end
        if (wr_at(`PF_OFS_DATA)) begin
            out_val_nxt = reg_wdata_i[`PF_HI_LSB +: PINS];
        end
        if (wr_at(`PF_OFS_IO_EN)) begin
            in_en_nxt  = reg_wdata_i[`PF_HI_LSB +: PINS];
            out_en_nxt = reg_wdata_i[PINS-1:0];
        end
        if (wr_at(`PF_OFS_PULL)) begin
            pull_dir_nxt = reg_wdata_i[`PF_HI_LSB +: PINS];
            pull_en_nxt  = reg_wdata_i[PINS-1:0];
        end
        if (wr_at(`PF_OFS_IRQ_CTRL)) begin
            edge_sel_nxt = reg_wdata_i[`PF_HI_LSB +: PINS];
            irq_en_nxt   = reg_wdata_i[PINS-1:0];
        end
        if (wr_at(`PF_OFS_FILT_EN)) begin
            filt_en_nxt = reg_wdata_i[PINS-1:0];
        end
        if (wr_at(`PF_OFS_MODE_SEL)) begin
            mode_nxt = reg_wdata_i[PINS-1:0];
        end
        if (wr_at(`PF_OFS_FUNC_SEL)) begin
            func_nxt = reg_wdata_i[2*PINS-1:0];
        end
        // a new event beats a clear in the same cycle
        flags_nxt = flags_r;
        if (wr_at(`PF_OFS_IRQ_FLAGS)) begin
            flags_nxt = flags_r & ~reg_wdata_i[PINS-1:0];
        end
        flags_nxt = flags_nxt | pin_event;
    end

    always_comb begin
        rd_mux = '0;
        unique case (reg_addr_i)
            `PF_OFS_CLK_CTRL: begin
                rd_mux[`PF_CLK_DEBUG_RUN_BIT]      = debug_run_r;
                rd_mux[`PF_CLK_DIV_LSB +: 4]   = clk_div_r;
                rd_mux[`PF_CLK_KRST_LSB +: 2]  = key_cfg_r;
                rd_mux[`PF_CLK_SRC_LSB +: 2]   = clk_src_r;
            end
            `PF_OFS_GRP_SUM:   rd_mux[12:0] = grp_sum;
            `PF_OFS_DATA:      rd_mux = pack_hi_lo(out_val_r, in_val);
            `PF_OFS_IO_EN:     rd_mux = pack_hi_lo(in_en_r, out_en_r);
            `PF_OFS_PULL:      rd_mux = pack_hi_lo(pull_dir_r, pull_en_r);
            `PF_OFS_IRQ_FLAGS: rd_mux[PINS-1:0] = flags_r;
            `PF_OFS_IRQ_CTRL:  rd_mux = pack_hi_lo(edge_sel_r, irq_en_r);
            `PF_OFS_FILT_EN:   rd_mux[PINS-1:0] = filt_en_r;
            `PF_OFS_MODE_SEL:  rd_mux[PINS-1:0] = mode_r;
            `PF_OFS_FUNC_SEL:  rd_mux[2*PINS-1:0] = func_r;
            default:           rd_mux = '0;
        endcase
        // read data stand for one cycle only
        rdata_nxt = reg_rd_i ? rd_mux : `PF_RESET_VAL;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            debug_run_r <= 1'b0;
            clk_div_r   <= '0;
            key_cfg_r   <= '0;
            clk_src_r   <= PF_SRC_INTERNAL;
            out_val_r   <= '0;
            in_en_r     <= '0;
            out_en_r    <= '0;
            pull_dir_r  <= '0;
            pull_en_r   <= '0;
            flags_r     <= '0;
            edge_sel_r  <= '0;
            irq_en_r    <= '0;
            filt_en_r   <= '0;
            mode_r      <= '0;
            func_r      <= '0;
            rdata_r     <= `PF_RESET_VAL;
        end else begin
            debug_run_r <= debug_run_nxt;
            clk_div_r   <= clk_div_nxt;
            key_cfg_r   <= key_cfg_nxt;
            clk_src_r   <= clk_src_nxt;
            out_val_r   <= out_val_nxt;
            in_en_r     <= in_en_nxt;
            out_en_r    <= out_en_nxt;
            pull_dir_r  <= pull_dir_nxt;
            pull_en_r   <= pull_en_nxt;
            flags_r     <= flags_nxt;
            edge_sel_r  <= edge_sel_nxt;
            irq_en_r    <= irq_en_nxt;
            filt_en_r   <= filt_en_nxt;
            mode_r      <= mode_nxt;
            func_r      <= func_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign reg_rdata_o      = rdata_r;
    assign group0_pending_o = |flags_r;
    assign key_reset_o      = key_rst_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    chk_key_two_low: assert property (
        (key_cfg_r == 2'h1 && filt_in[1:0] == 2'b00) |=> key_reset_o)
        else $error("key reset missing with two low inputs");
    chk_key_disabled: assert property (
        (key_cfg_r == 2'h0) |=> !key_reset_o)
        else $error("key reset asserted while disabled");
    chk_key_release: assert property (
        (key_cfg_r == 2'h3 && |filt_in[3:0]) |=> !key_reset_o)
        else $error("key reset held with an input high");
    chk_div_bypass: assert property (
        (clk_div_r == 4'h0 && src_tick_sel && clk_run) |-> port_tick)
        else $error("divide by one missed a source tick");
    chk_tick_source: assert property (
        port_tick |-> src_tick_i[clk_src_r])
        else $error("port tick without selected source tick");
    chk_debug_stop: assert property (
        (!debug_run_r && debug_mode_i) |-> !port_tick)
        else $error("port clock ran in debug mode");
    chk_src_legal: assert property (
        SRC_PRESENT[clk_src_r])
        else $error("absent clock source selected");
    chk_summary_read: assert property (
        (reg_rd_i && reg_addr_i == `PF_OFS_GRP_SUM && |flags_r &&
         GRP_IRQ_MASK[0]) |=> reg_rdata_o[0] && reg_rdata_o[15:13] == 3'h0)
        else $error("summary bit not set with pending flag");
    chk_w1c_clear: assert property (
        (wr_at(`PF_OFS_IRQ_FLAGS) && reg_wdata_i[0] && !pin_event[0])
        |=> !flags_r[0])
        else $error("written one did not clear flag");
    chk_edge_flag: assert property (
        pin_event[0] |=> flags_r[0] [*2])
        else $error("pin event did not hold its flag");
    chk_data_resv: assert property (
        (reg_rd_i && reg_addr_i == `PF_OFS_DATA)
        |=> reg_rdata_o[15] == 1'b0 && reg_rdata_o[7] == 1'b0)
        else $error("reserved data bits read nonzero");
    chk_pin_float: assert property (
        (!mode_r[0] && !out_en_r[0]) |-> pin_oe_n_o[0])
        else $error("disabled output driven");

    cov_key_reset:  cover property ($rose(key_reset_o));
    cov_flag_set:   cover property (pin_event[0] ##1 flags_r[0]);
    cov_div_tick:   cover property (clk_div_r == 4'h3 && port_tick);

endmodule : pf_port_ctrl

`default_nettype wire

/* verification/pf_pad_model.sv */
// pad model of the seven group-zero pins
// assumes active-low output enables from the port controller
`timescale 1ns/1ps
`default_nettype none

module pf_pad_model (
    // controller side
    input  wire logic [6:0] out_i,
    input  wire logic [6:0] oe_n_i,
    input  wire logic [6:0] pu_en_i,
    input  wire logic [6:0] pu_dir_i,
    // outside world
    input  wire logic [6:0] ext_en_i,
    input  wire logic [6:0] ext_val_i,
    output logic      [6:0] pad_o
);
    // a floating pin shows the inverse level, never a convenient hold
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (!oe_n_i[i]) pad_o[i] = out_i[i];
            else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
            else if (pu_en_i[i]) pad_o[i] = pu_dir_i[i];
            else pad_o[i] = ~ext_val_i[i];
        end
    end
endmodule : pf_pad_model

`default_nettype wire

/* verification/pf_port_ctrl_tb.sv */
// self-checking bench of the group-zero port controller
// assumes all source ticks run every cycle unless a test says otherwise
`timescale 1ns/1ps
`default_nettype none
`include "pf_port_cfg.svh"

module pf_port_ctrl_tb;
    import pf_port_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [4:0]  reg_addr_i = 5'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        dbg = 1'b0;
    logic [3:0]  tick = 4'hf;
    logic [11:0] gp = 12'h000;
    logic [6:0]  ext_en = 7'h7f;
    logic [6:0]  ext_val = 7'h00;
    logic [6:0]  pad, pout, poe_n, pen, pdir, p_in, u_in;
    logic        g0p, krst;
    int          n_mismatch = 0;
    int          n_tests = 0;

    always #2 clock_i = ~clock_i;

    pf_port_ctrl u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .src_tick_i(tick), .debug_mode_i(dbg), .pin_in_i(pad),
        .pin_out_o(pout), .pin_oe_n_o(poe_n), .pull_enable_o(pen),
        .pull_direction_o(pdir), .periph_out_i(7'h00), .periph_oe_i(7'h00),
        .periph_in_o(p_in), .universal_port_multiplexer_out_i(7'h00), .universal_port_multiplexer_oe_i(7'h00),
        .universal_port_multiplexer_in_o(u_in), .group_pending_i(gp),
        .group0_pending_o(g0p), .key_reset_o(krst));

    pf_pad_model u_pad (.out_i(pout), .oe_n_i(poe_n), .pu_en_i(pen),
        .pu_dir_i(pdir), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        // read data stand for this cycle only, so look mid-cycle
        @(negedge clock_i);
        chk(reg_rdata_o, e);
        @(posedge clock_i);
    endtask : rd_chk

    task automatic waitc(input int n);
        repeat (n) @(posedge clock_i);
        // outputs are looked at mid-cycle, clear of the launching edge
        @(negedge clock_i);
    endtask : waitc

    ////////////////////////////////////////////////////////////////////////
    task automatic t_fields();
        logic [4:0]  ofs [5] = '{`PF_OFS_DATA, `PF_OFS_FUNC_SEL,
            `PF_OFS_MODE_SEL, `PF_OFS_FILT_EN, `PF_OFS_CLK_CTRL};
        logic [15:0] msk [5] = '{16'h7f00, 16'h3fff, 16'h007f,
            16'h007f, 16'h01fc};
        for (int a = 0; a < 22; a += 2) rd_chk(5'(a), 16'h0000);
        waitc(0);
        chk({9'h0, poe_n}, 16'h007f);
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 16'hffff);
            rd_chk(ofs[i], msk[i]);
            wr(ofs[i], 16'h0000);
        end
        wr(`PF_OFS_CLK_CTRL, 16'h0002);
        rd_chk(`PF_OFS_CLK_CTRL, 16'h0002);
        wr(`PF_OFS_CLK_CTRL, 16'h0000);
        wr(5'h16, 16'hffff);
        rd_chk(5'h16, 16'h0000);
    endtask : t_fields

    task automatic t_pins();
        wr(`PF_OFS_DATA, 16'h0500);
        wr(`PF_OFS_IO_EN, 16'h0007);
        waitc(0);
        chk({9'h0, poe_n}, 16'h0078);
        chk({9'h0, pad & ~poe_n}, 16'h0005);
        wr(`PF_OFS_IO_EN, 16'h0000);
        wr(`PF_OFS_PULL, 16'h0202);
        waitc(0);
        chk({1'b0, pdir, 1'b0, pen}, 16'h0202);
        wr(`PF_OFS_PULL, 16'h0000);
        wr(`PF_OFS_DATA, 16'h0000);
    endtask : t_pins

    task automatic t_irq();
        wr(`PF_OFS_IO_EN, 16'h0100);
        wr(`PF_OFS_IRQ_CTRL, 16'h0001);
        gp <= 12'hfff;
        ext_val <= 7'h01;
        waitc(4);
        chk({15'h0, g0p}, 16'h0001);
        rd_chk(`PF_OFS_GRP_SUM, 16'h0007);
        wr(`PF_OFS_IRQ_FLAGS, 16'h0000);
        rd_chk(`PF_OFS_IRQ_FLAGS, 16'h0001);
        wr(`PF_OFS_IRQ_FLAGS, 16'h0001);
        gp <= 12'h000;
        rd_chk(`PF_OFS_GRP_SUM, 16'h0000);
        wr(`PF_OFS_IRQ_CTRL, 16'h0101);
        ext_val <= 7'h00;
        waitc(4);
        rd_chk(`PF_OFS_IRQ_FLAGS, 16'h0001);
        wr(`PF_OFS_IRQ_FLAGS, 16'h0001);
        wr(`PF_OFS_IRQ_CTRL, 16'h0000);
    endtask : t_irq

    task automatic t_key();
        for (int k = 0; k < 4; k++) begin
            wr(`PF_OFS_CLK_CTRL, 16'(k << 2));
            ext_val <= 7'((7'h7f << (k + 1)) & 7'h7f);
            waitc(4);
            chk({15'h0, krst}, 16'(k != 0));
            @(posedge clock_i);
            ext_val <= 7'(((7'h7f << (k + 1)) | (1 << k)) & 7'h7f);
            waitc(4);
            chk({15'h0, krst}, 16'h0000);
        end
        wr(`PF_OFS_CLK_CTRL, 16'h0000);
    endtask : t_key

    task automatic t_filter();
        ext_val <= 7'h00;
        wr(`PF_OFS_IO_EN, 16'h0100);
        wr(`PF_OFS_FILT_EN, 16'h0001);
        wr(`PF_OFS_CLK_CTRL, 16'h0020);
        waitc(40);
        @(posedge clock_i);
        dbg <= 1'b1;
        ext_val <= 7'h01;
        waitc(40);
        rd_chk(`PF_OFS_DATA, 16'h0000);
        dbg <= 1'b0;
        waitc(4);
        rd_chk(`PF_OFS_DATA, 16'h0000);
        waitc(14);
        rd_chk(`PF_OFS_DATA, 16'h0001);
        // only unselected sources tick, so the filter must hold its level
        tick <= 4'he;
        ext_val <= 7'h00;
        waitc(40);
        rd_chk(`PF_OFS_DATA, 16'h0001);
        ext_val <= 7'h01;
        wr(`PF_OFS_MODE_SEL, 16'h0001);
        wr(`PF_OFS_FUNC_SEL, 16'h0001);
        waitc(0);
        chk({2'h0, p_in, u_in}, 16'h0001);
        wr(`PF_OFS_FUNC_SEL, 16'h0000);
        waitc(0);
        chk({2'h0, p_in, u_in}, 16'h0080);
    endtask : t_filter

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_fields();
        t_pins();
        t_irq();
        t_key();
        t_filter();
        conclude();
    end

    // whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        conclude();
    end
endmodule : pf_port_ctrl_tb

`default_nettype wire
